// >>> rtl/fswg_pkg.sv
// Purpose: Shared constants and types for the flash sector write guard.
// Assumes: 25-bit main array address carried in a 32-bit address field.
// Notes: Opcodes and status bit positions are plain defaults.
package fswg_pkg;
  // Array geometry
  localparam int SECTORS = 512;
  localparam int SUBSECTORS = 8192;
  localparam int PAGES = 131072;
  localparam int PAGE_BYTES = 256;
  localparam int ARRAY_BYTES = 33554432;
  localparam int OTP_BYTES = 64;
  localparam int SEC_LSB = 16;
  localparam int SUB_LSB = 12;
  localparam int ADDR_MSB = 24;
  // Frame header: opcode, four address bytes, one data byte
  localparam int HDR_BITS = 48;
  localparam int ADDR_FRAME_BITS = 40;
  localparam int STAT_FRAME_BITS = 16;
  // Command opcodes
  localparam logic [7:0] OP_WR_EN = 8'h06;
  localparam logic [7:0] OP_WR_DIS = 8'h04;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_SUB_ERASE = 8'h20;
  localparam logic [7:0] OP_SEC_ERASE = 8'hD8;
  localparam logic [7:0] OP_BULK_ERASE = 8'hC7;
  localparam logic [7:0] OP_WR_LOCK = 8'hE5;
  localparam logic [7:0] OP_WR_STATUS = 8'h01;
  // Status byte of the status-write command
  localparam int SB_BP_LO = 2;
  localparam int SB_TB = 5;
  localparam int SB_BP3 = 6;
  // Lock-register data byte
  localparam int LK_WLOCK = 0;
  localparam int LK_LDOWN = 1;
  localparam int BP_ALL_FROM = 10;
  // Timing at a 50 ns core clock
  localparam int CLK_PERIOD_NS = 50;
  localparam int POR_TIME_NS = 100000;
  localparam int POR_CYC = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CYC = 3;
  // Register map (byte addresses)
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_LOCK_SEL = 8'h04;
  localparam logic [7:0] REG_LOCK_VIEW = 8'h08;
  localparam logic [7:0] REG_RESULT = 8'h0C;
  localparam logic [7:0] REG_COUNT = 8'h10;
  // Status, result and count register fields; bus response codes
  localparam int RS_WEL = 0;
  localparam int RS_BP_LO = 1;
  localparam int RS_TB = 5;
  localparam int RS_WP = 6;
  localparam int RS_POR = 7;
  localparam int RS_STATE_LO = 8;
  localparam int RR_OP_LO = 8;
  localparam int RR_BITS_LO = 16;
  localparam int RC_REJ_LO = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    K_NONE = 3'b000, K_PROG = 3'b001, K_SUB = 3'b010, K_SEC = 3'b011,
    K_BULK = 3'b100, K_LOCK = 3'b101, K_STATUS = 3'b110
  } fswg_kind_t;
  typedef enum logic [3:0] {
    RSN_OK = 4'b0000, RSN_POR = 4'b0001, RSN_PARTIAL = 4'b0010,
    RSN_NO_WEL = 4'b0011, RSN_SHORT = 4'b0100, RSN_RANGE = 4'b0101,
    RSN_BP = 4'b0110, RSN_WLOCK = 4'b0111, RSN_LDOWN = 4'b1000,
    RSN_WP = 4'b1001, RSN_UNKNOWN = 4'b1010
  } fswg_reason_t;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_FRAME = 3'b001, S_SETTLE = 3'b010,
    S_DRAIN = 3'b011, S_DECIDE = 3'b100
  } fswg_state_t;
endpackage : fswg_pkg

// >>> rtl/fswg_link.sv
// Purpose: Serial-clock side; packs bit pairs into an 8-entry ring.
// Assumes: Data sampled on rising link_clk while sel_n is low.
// Notes: Pointer leaves gray coded; a lone bit waits in pend.
`timescale 1ns/1ps
module fswg_link (
  input wire logic link_clk,
  input wire logic rst_n,
  input wire logic sel_n,
  input wire logic mosi,
  output logic [3:0] wptr_gray,
  output logic half,
  output logic [15:0] ring
);
  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic pend;
    logic half;
    logic [3:0] wptr;
    logic [3:0] wgray;
    logic [15:0] ring;
  } fswg_link_st_t;

  fswg_link_st_t q_reg;
  fswg_link_st_t q_next;
  logic [3:0] wp_inc;

  // Pair bits; ring slot is written on the same edge that moves the pointer
  always_comb begin
    q_next = q_reg;
    wp_inc = q_reg.wptr + 4'h1;
    q_next.rst_s1 = rst_n;
    q_next.rst_s2 = q_reg.rst_s1;
    if (!q_reg.rst_s2) begin
      q_next.pend = 1'b0;
      q_next.half = 1'b0;
      q_next.wptr = 4'h0;
      q_next.wgray = 4'h0;
      q_next.ring = 16'h0000;
    end else if (!sel_n) begin
      if (!q_reg.half) begin
        q_next.pend = mosi;
        q_next.half = 1'b1;
        // Park it in the open slot too, so a lone last bit can be read
        q_next.ring[{q_reg.wptr[2:0], 1'b1}] = mosi;
      end else begin
        q_next.ring[{q_reg.wptr[2:0], 1'b0} +: 2] = {q_reg.pend, mosi};
        q_next.wptr = wp_inc;
        q_next.wgray = wp_inc ^ (wp_inc >> 1);
        q_next.half = 1'b0;
      end
    end
  end

  always_ff @(posedge link_clk) begin
    q_reg <= q_next;
  end

  assign wptr_gray = q_reg.wgray;
  assign half = q_reg.half;
  assign ring = q_reg.ring;
endmodule : fswg_link

// >>> rtl/fswg_guard.sv
// Purpose: Decides whether program, erase and register writes may run.
// Assumes: Host frames arrive on link_clk; registers over AXI4-Lite.
// Notes: Array itself lives elsewhere; this block issues exec or reject.
// Notes on behaviour
// - Program clears bits only, never sets them.
// - Erase by subsector, sector or bulk only.
// - 512 sectors, 8192 subsectors, 256-byte pages.
// - OTP bytes unreachable through main array addresses.
// - Refuse commands of partial byte length.
// - Modification needs write-enable latch set first.
// - Block modification during power-on delay.
// - Set write-lock bit refuses program and erase.
// - Lock-down freezes write-lock until reset.
// - Lock write ignored while lock-down set.
// - All sectors write-locked after reset.
// - Top-side protect code covers highest sectors.
// - Bottom-side protect code covers lowest sectors.
// - Protect code frozen while write-protect pin low.
//
// Implementation choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module fswg_guard (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic sel_n,
  input wire logic mosi,
  input wire logic wp_n,
  input wire logic [7:0] prog_old_byte,
  input wire logic [7:0] prog_new_byte,
  output logic [7:0] prog_merged_byte,
  output logic exec_valid,
  output logic [2:0] exec_kind,
  output logic [24:0] exec_addr,
  output logic reject_valid,
  output logic [3:0] reject_reason,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic wp_s1;
    logic wp_s2;
    logic [3:0] wg_s1;
    logic [3:0] wg_s2;
    logic hf_s1;
    logic hf_s2;
    fswg_pkg::fswg_state_t st;
    logic [3:0] rptr;
    logic skip;
    logic carry;
    logic [15:0] fbits;
    logic [47:0] hdr;
    logic [1:0] settle;
    logic [11:0] por;
    logic wel;
    logic [3:0] bp;
    logic tb;
    logic [511:0] wlock;
    logic [511:0] ldown;
    logic exec_v;
    logic [2:0] exec_k;
    logic [24:0] exec_a;
    logic rej_v;
    logic [3:0] rej_r;
    logic [7:0] merged;
    logic [8:0] lock_sel;
    logic [7:0] last_op;
    logic [3:0] last_res;
    logic [7:0] n_ok;
    logic [7:0] n_rej;
    logic aw_h;
    logic [7:0] aw_a;
    logic w_h;
    logic [31:0] w_d;
    logic [3:0] w_s;
    logic bv;
    logic [1:0] br;
    logic rv;
    logic [31:0] rd;
    logic [1:0] rr;
  } fswg_st_t;

  fswg_st_t q_reg;
  fswg_st_t q_next;
  logic [3:0] lk_wgray;
  logic lk_half;
  logic [15:0] lk_ring;
  logic [3:0] wbin;
  logic avail;
  logic [7:0] op;
  logic [31:0] addr;
  logic [8:0] sec;
  logic bp_hit;
  logic is_addr_op;

  // Serial-clock side; everything it hands over crosses below
  fswg_link u_link (
    .link_clk(link_clk),
    .rst_n(rst_n),
    .sel_n(sel_n),
    .mosi(mosi),
    .wptr_gray(lk_wgray),
    .half(lk_half),
    .ring(lk_ring)
  );

  function automatic logic [3:0] gray2bin(input logic [3:0] g);
    logic [3:0] b;
    b[3] = g[3];
    for (int i = 2; i >= 0; i--) begin
      b[i] = b[i + 1] ^ g[i];
    end
    return b;
  endfunction : gray2bin

  // Protect-code decode: 1..9 cover 2^(k-1) sectors, 10..15 all
  function automatic logic bp_covers(input logic [3:0] code, input logic tb,
                                     input logic [8:0] s);
    logic [9:0] span;
    span = 10'h001 << (code - 4'h1);
    if (code == 4'h0) return 1'b0;
    if (code >= 4'(fswg_pkg::BP_ALL_FROM)) return 1'b1;
    if (tb) return {1'b0, s} < span;
    return {1'b0, s} >= (10'(fswg_pkg::SECTORS) - span);
  endfunction : bp_covers

  // Header fields and protection lookups of the finished frame
  always_comb begin
    wbin = gray2bin(q_reg.wg_s2);
    avail = wbin != q_reg.rptr;
    op = q_reg.hdr[47:40];
    addr = q_reg.hdr[39:8];
    sec = addr[fswg_pkg::ADDR_MSB:fswg_pkg::SEC_LSB];
    bp_hit = bp_covers(q_reg.bp, q_reg.tb, sec);
    is_addr_op = (op == fswg_pkg::OP_PROG) || (op == fswg_pkg::OP_SUB_ERASE)
                 || (op == fswg_pkg::OP_SEC_ERASE);
  end

  // Next-state logic for frame assembly, decisions and the bus slave
  always_comb begin
    logic [1:0] ent;
    logic [3:0] rsn;
    logic [2:0] kind;
    logic modify;
    ent = lk_ring[{q_reg.rptr[2:0], 1'b0} +: 2];
    rsn = fswg_pkg::RSN_OK;
    kind = fswg_pkg::K_NONE;
    modify = 1'b0;
    q_next = q_reg;
    q_next.exec_v = 1'b0;
    q_next.rej_v = 1'b0;
    q_next.merged = prog_old_byte & prog_new_byte;
    if (q_reg.por != 12'h000) begin
      q_next.por = q_reg.por - 12'h001;
    end
    // Pop one bit pair; a bit left from the last frame is dropped
    if (avail && q_reg.st != fswg_pkg::S_IDLE && q_reg.st != fswg_pkg::S_DECIDE) begin
      q_next.rptr = q_reg.rptr + 4'h1;
      if (q_reg.skip) begin
        q_next.skip = 1'b0;
        if (q_reg.fbits < 16'(fswg_pkg::HDR_BITS)) begin
          q_next.hdr[6'(fswg_pkg::HDR_BITS - 1) - 6'(q_reg.fbits)] = ent[0];
        end
        q_next.fbits = q_reg.fbits + 16'h0001;
      end else begin
        if (q_reg.fbits < 16'(fswg_pkg::HDR_BITS)) begin
          q_next.hdr[6'(fswg_pkg::HDR_BITS - 1) - 6'(q_reg.fbits)] = ent[1];
          q_next.hdr[6'(fswg_pkg::HDR_BITS - 2) - 6'(q_reg.fbits)] = ent[0];
        end
        q_next.fbits = q_reg.fbits + 16'h0002;
      end
    end
    // Frame sequencer
    case (q_reg.st)
      fswg_pkg::S_IDLE: begin
        if (!q_reg.cs_s2) begin
          q_next.st = fswg_pkg::S_FRAME;
          q_next.skip = q_reg.carry;
          q_next.fbits = 16'h0000;
          q_next.hdr = 48'h000000000000;
        end
      end
      fswg_pkg::S_FRAME: begin
        if (q_reg.cs_s2) begin
          q_next.st = fswg_pkg::S_SETTLE;
          q_next.settle = 2'(fswg_pkg::SETTLE_CYC);
        end
      end
      fswg_pkg::S_SETTLE: begin
        // Link clock is stopped now; let the pointer sync catch up
        q_next.settle = q_reg.settle - 2'h1;
        if (q_reg.settle == 2'h0) begin
          q_next.st = fswg_pkg::S_DRAIN;
        end
      end
      fswg_pkg::S_DRAIN: begin
        if (!avail) begin
          q_next.st = fswg_pkg::S_DECIDE;
          q_next.fbits = q_reg.fbits + {15'h0000, q_reg.hf_s2};
          q_next.carry = q_reg.hf_s2;
          // Lone last bit sits in the upper half of the unpublished slot
          if (q_reg.hf_s2 && !q_reg.skip && q_reg.fbits < 16'(fswg_pkg::HDR_BITS)) begin
            q_next.hdr[6'(fswg_pkg::HDR_BITS - 1) - 6'(q_reg.fbits)] = ent[1];
          end
        end
      end
      fswg_pkg::S_DECIDE: begin
        q_next.st = fswg_pkg::S_IDLE;
        modify = (op == fswg_pkg::OP_BULK_ERASE) || (op == fswg_pkg::OP_WR_LOCK)
                 || (op == fswg_pkg::OP_WR_STATUS) || is_addr_op;
        if (q_reg.por != 12'h000) begin
          rsn = fswg_pkg::RSN_POR;
        end else if (q_reg.fbits[2:0] != 3'h0) begin
          rsn = fswg_pkg::RSN_PARTIAL;
        end else if (op == fswg_pkg::OP_WR_EN) begin
          q_next.wel = 1'b1;
        end else if (op == fswg_pkg::OP_WR_DIS) begin
          q_next.wel = 1'b0;
        end else if (!modify) begin
          rsn = fswg_pkg::RSN_UNKNOWN;
        end else if (!q_reg.wel) begin
          rsn = fswg_pkg::RSN_NO_WEL;
        end else begin
          q_next.wel = 1'b0;
          if (op == fswg_pkg::OP_BULK_ERASE) begin
            // Bulk erase needs the whole array free
            if (q_reg.bp != 4'h0) rsn = fswg_pkg::RSN_BP;
            else if (|q_reg.wlock) rsn = fswg_pkg::RSN_WLOCK;
            else kind = fswg_pkg::K_BULK;
          end else if (op == fswg_pkg::OP_WR_STATUS) begin
            if (q_reg.fbits < 16'(fswg_pkg::STAT_FRAME_BITS)) begin
              rsn = fswg_pkg::RSN_SHORT;
            end else if (!q_reg.wp_s2) begin
              rsn = fswg_pkg::RSN_WP;
            end else begin
              kind = fswg_pkg::K_STATUS;
              q_next.bp = {q_reg.hdr[32 + fswg_pkg::SB_BP3],
                           q_reg.hdr[32 + fswg_pkg::SB_BP_LO +: 3]};
              q_next.tb = q_reg.hdr[32 + fswg_pkg::SB_TB];
            end
          end else if (q_reg.fbits < 16'(fswg_pkg::ADDR_FRAME_BITS)) begin
            rsn = fswg_pkg::RSN_SHORT;
          end else if (addr[31:fswg_pkg::ADDR_MSB + 1] != 7'h00) begin
            rsn = fswg_pkg::RSN_RANGE;
          end else if (op == fswg_pkg::OP_WR_LOCK) begin
            if (q_reg.fbits < 16'(fswg_pkg::HDR_BITS)) begin
              rsn = fswg_pkg::RSN_SHORT;
            end else if (q_reg.ldown[sec]) begin
              rsn = fswg_pkg::RSN_LDOWN;
            end else begin
              kind = fswg_pkg::K_LOCK;
              q_next.wlock[sec] = q_reg.hdr[fswg_pkg::LK_WLOCK];
              q_next.ldown[sec] = q_reg.hdr[fswg_pkg::LK_LDOWN];
            end
          end else if (bp_hit) begin
            rsn = fswg_pkg::RSN_BP;
          end else if (q_reg.wlock[sec]) begin
            rsn = fswg_pkg::RSN_WLOCK;
          end else if (op == fswg_pkg::OP_PROG) begin
            kind = fswg_pkg::K_PROG;
          end else if (op == fswg_pkg::OP_SUB_ERASE) begin
            kind = fswg_pkg::K_SUB;
          end else begin
            kind = fswg_pkg::K_SEC;
          end
        end
        q_next.last_op = op;
        q_next.last_res = rsn;
        q_next.exec_k = kind;
        q_next.exec_a = addr[fswg_pkg::ADDR_MSB:0];
        q_next.exec_v = (kind == fswg_pkg::K_PROG) || (kind == fswg_pkg::K_SUB)
                        || (kind == fswg_pkg::K_SEC) || (kind == fswg_pkg::K_BULK);
        q_next.rej_v = rsn != fswg_pkg::RSN_OK;
        q_next.rej_r = rsn;
        if (rsn != fswg_pkg::RSN_OK) q_next.n_rej = q_reg.n_rej + 8'h01;
        else q_next.n_ok = q_reg.n_ok + 8'h01;
      end
      default: begin
        q_next.st = fswg_pkg::S_IDLE;
      end
    endcase
    // Bus slave: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      q_next.aw_h = 1'b1;
      q_next.aw_a = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      q_next.w_h = 1'b1;
      q_next.w_d = s_axi_wdata;
      q_next.w_s = s_axi_wstrb;
    end
    if (q_reg.aw_h && q_reg.w_h) begin
      q_next.aw_h = 1'b0;
      q_next.w_h = 1'b0;
      q_next.bv = 1'b1;
      q_next.br = fswg_pkg::RESP_OKAY;
      case ({q_reg.aw_a[7:2], 2'h0})
        fswg_pkg::REG_LOCK_SEL: begin
          if (q_reg.w_s[0]) q_next.lock_sel[7:0] = q_reg.w_d[7:0];
          if (q_reg.w_s[1]) q_next.lock_sel[8] = q_reg.w_d[8];
        end
        fswg_pkg::REG_STATUS, fswg_pkg::REG_LOCK_VIEW, fswg_pkg::REG_RESULT,
        fswg_pkg::REG_COUNT: begin
          q_next.br = fswg_pkg::RESP_OKAY;
        end
        default: begin
          q_next.br = fswg_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (q_reg.bv && s_axi_bready) q_next.bv = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      q_next.rv = 1'b1;
      q_next.rr = fswg_pkg::RESP_OKAY;
      q_next.rd = 32'h00000000;
      case ({s_axi_araddr[7:2], 2'h0})
        fswg_pkg::REG_STATUS: begin
          q_next.rd[fswg_pkg::RS_WEL] = q_reg.wel;
          q_next.rd[fswg_pkg::RS_BP_LO +: 4] = q_reg.bp;
          q_next.rd[fswg_pkg::RS_TB] = q_reg.tb;
          q_next.rd[fswg_pkg::RS_WP] = q_reg.wp_s2;
          q_next.rd[fswg_pkg::RS_POR] = q_reg.por != 12'h000;
          q_next.rd[fswg_pkg::RS_STATE_LO +: 3] = q_reg.st;
        end
        fswg_pkg::REG_LOCK_SEL: q_next.rd[8:0] = q_reg.lock_sel;
        fswg_pkg::REG_LOCK_VIEW: begin
          q_next.rd[fswg_pkg::LK_WLOCK] = q_reg.wlock[q_reg.lock_sel];
          q_next.rd[fswg_pkg::LK_LDOWN] = q_reg.ldown[q_reg.lock_sel];
        end
        fswg_pkg::REG_RESULT: begin
          q_next.rd[3:0] = q_reg.last_res;
          q_next.rd[fswg_pkg::RR_OP_LO +: 8] = q_reg.last_op;
          q_next.rd[fswg_pkg::RR_BITS_LO +: 16] = q_reg.fbits;
        end
        fswg_pkg::REG_COUNT: begin
          q_next.rd[7:0] = q_reg.n_ok;
          q_next.rd[fswg_pkg::RC_REJ_LO +: 8] = q_reg.n_rej;
        end
        default: q_next.rr = fswg_pkg::RESP_SLVERR;
      endcase
    end
    if (q_reg.rv && s_axi_rready) q_next.rv = 1'b0;
    // Reset; read pointer follows the link so the ring starts empty
    if (!rst_n) begin
      q_next = '0;
      q_next.wlock = '1;
      q_next.por = 12'(fswg_pkg::POR_CYC);
      q_next.rptr = wbin;
    end
    // Two-stage synchronisers for pins and link-side words
    q_next.cs_s1 = sel_n;
    q_next.cs_s2 = q_reg.cs_s1;
    q_next.wp_s1 = wp_n;
    q_next.wp_s2 = q_reg.wp_s1;
    q_next.wg_s1 = lk_wgray;
    q_next.wg_s2 = q_reg.wg_s1;
    q_next.hf_s1 = lk_half;
    q_next.hf_s2 = q_reg.hf_s1;
  end

  always_ff @(posedge core_clk) begin
    q_reg <= q_next;
  end

  // Handshake readies are combinational, data from flops
  assign s_axi_awready = !q_reg.aw_h && !q_reg.bv;
  assign s_axi_wready = !q_reg.w_h && !q_reg.bv;
  assign s_axi_arready = !q_reg.rv;
  assign s_axi_bvalid = q_reg.bv;
  assign s_axi_bresp = q_reg.br;
  assign s_axi_rvalid = q_reg.rv;
  assign s_axi_rdata = q_reg.rd;
  assign s_axi_rresp = q_reg.rr;
  assign prog_merged_byte = q_reg.merged;
  assign exec_valid = q_reg.exec_v;
  assign exec_kind = q_reg.exec_k;
  assign exec_addr = q_reg.exec_a;
  assign reject_valid = q_reg.rej_v;
  assign reject_reason = q_reg.rej_r;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_decide_clean;
    q_reg.st == fswg_pkg::S_DECIDE && q_reg.por == 12'h000 && q_reg.fbits[2:0] == 3'h0;
  endsequence
  sequence s_frame_closed;
    q_reg.st == fswg_pkg::S_FRAME ##1 q_reg.st == fswg_pkg::S_SETTLE;
  endsequence

  a_no_raise: assert property ((q_reg.merged & ~$past(prog_old_byte)) == 8'h00)
    else $error("program merge raised a bit");
  a_partial_refused: assert property (
    (q_reg.st == fswg_pkg::S_DECIDE && q_reg.por == 12'h000 && q_reg.fbits[2:0] != 3'h0)
    |=> (q_reg.rej_v && q_reg.rej_r == fswg_pkg::RSN_PARTIAL && !q_reg.exec_v))
    else $error("partial-byte frame not refused");
  a_frame_decided: assert property (s_frame_closed |-> ##[4:20] q_reg.st == fswg_pkg::S_DECIDE)
    else $error("closed frame never checked");
  a_exec_needs_wel: assert property (q_reg.exec_v |-> $past(q_reg.wel) && !q_reg.wel)
    else $error("execution without write-enable latch");
  a_wren_sets: assert property ((s_decide_clean and op == fswg_pkg::OP_WR_EN) |=> q_reg.wel)
    else $error("write enable did not set latch");
  a_por_blocks: assert property (
    (q_reg.st == fswg_pkg::S_DECIDE && q_reg.por != 12'h000)
    |=> (!q_reg.exec_v && q_reg.rej_r == fswg_pkg::RSN_POR && q_reg.wel == $past(q_reg.wel)))
    else $error("command ran during power-on delay");
  a_wlock_refuses: assert property (
    (q_reg.exec_v && q_reg.exec_k != fswg_pkg::K_BULK) |-> !q_reg.wlock[q_reg.exec_a[24:16]])
    else $error("write-locked sector modified");
  a_lockdown_frozen: assert property (
    ($past(q_reg.ldown) & ($past(q_reg.wlock) ^ q_reg.wlock)) == 512'h0)
    else $error("locked-down sector changed its write lock");
  a_locks_at_reset: assert property (!$past(rst_n) |-> (&q_reg.wlock && ~|q_reg.ldown))
    else $error("sectors not all locked after reset");
  a_bp_refuses: assert property (
    (s_decide_clean and (is_addr_op && bp_hit)) |=> !q_reg.exec_v)
    else $error("protect-code area modified");
  a_bulk_clear: assert property (
    (q_reg.exec_v && q_reg.exec_k == fswg_pkg::K_BULK) |-> (q_reg.bp == 4'h0 && ~|q_reg.wlock))
    else $error("bulk erase with a protected sector");
  a_wp_holds: assert property (
    !$past(q_reg.wp_s2) |-> (q_reg.bp == $past(q_reg.bp) && q_reg.tb == $past(q_reg.tb)))
    else $error("protect code changed while pin held low");
endmodule : fswg_guard

// >>> test/fswg_host.sv
// Purpose: Host serial controller model sending command frames.
// Assumes: Clock idles low and stands still between frames.
// Notes: Deselected data line shows the inverse of its last bit.
`timescale 1ns/1ps
module fswg_host (
  output logic link_clk,
  output logic sel_n,
  output logic mosi
);
  initial begin
    link_clk = 1'b0;
    sel_n = 1'b1;
    mosi = 1'b0;
  end
  // Whole frame, MSB first, 32 ns period
  task automatic send(input logic [47:0] f, input int n);
    #7 sel_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      mosi = f[47-i];
      #16 link_clk = 1'b1;
      #16 link_clk = 1'b0;
    end
    #16 sel_n = 1'b1;
    mosi = ~mosi;
  endtask : send
  // Deselected edges so the link side sees reset
  task automatic idle(input int n);
    repeat (n) begin
      #16 link_clk = 1'b1;
      #16 link_clk = 1'b0;
    end
  endtask : idle
endmodule : fswg_host

// >>> test/fswg_guard_tb.sv
// Purpose: Self-checking bench for the sector write guard.
// Assumes: Power-on delay of 2000 core cycles is waited out.
// Notes: Outcome code 1k is exec of kind k, 2r reject of reason r.
`timescale 1ns/1ps
module fswg_guard_tb;
  logic core_clk, rst_n = 1'b0, wp_n = 1'b1, link_clk, sel_n, mosi, exec_valid, reject_valid;
  logic [7:0] prog_old_byte = 8'h00, prog_new_byte = 8'h00, prog_merged_byte;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [2:0] exec_kind;
  logic [24:0] exec_addr, ea;
  logic [3:0] reject_reason, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [5:0] ev;
  int fail_count = 0;
  int n_checks = 0;
  localparam logic [7:0] SE = fswg_pkg::OP_SEC_ERASE, PRG = fswg_pkg::OP_PROG;
  localparam logic [7:0] LCK = fswg_pkg::OP_WR_LOCK, ST = fswg_pkg::REG_STATUS;
  localparam logic [31:0] A5 = 32'h00051234;
  // Code, side and outcome of a program into sector 5
  localparam logic [10:0] BPT [7] = '{11'h526, 11'h4D1, 11'h251, 11'h2A6, 11'h7E6, 11'h051, 11'h411};
  fswg_host i_host (.link_clk, .sel_n, .mosi);
  fswg_guard i_dut (.core_clk, .rst_n, .link_clk, .sel_n, .mosi, .wp_n, .prog_old_byte,
    .prog_new_byte, .prog_merged_byte, .exec_valid, .exec_kind, .exec_addr, .reject_valid,
    .reject_reason, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // Core clock, 50 ns
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  // Each channel released on its own handshake
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(34'(s_axi_bresp), 34'(fswg_pkg::RESP_OKAY));
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                    input logic [1:0] er);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk({s_axi_rresp, s_axi_rdata & m}, {er, e});
  endtask : rd
  // Fixed 40-cycle window also keeps the gap between frames
  task automatic frame(input logic [47:0] f, input int n, input logic [5:0] exp);
    ev = 6'h00;
    i_host.send(f, n);
    repeat (40) begin
      @(posedge core_clk);
      if (exec_valid === 1'b1) begin
        ev = {3'h2, exec_kind};
        ea = exec_addr;
      end
      if (reject_valid === 1'b1) ev = {2'h2, reject_reason};
    end
    chk(34'(ev), 34'(exp));
  endtask : frame
  task automatic mod(input logic [47:0] f, input int n, input logic [5:0] exp);
    frame({fswg_pkg::OP_WR_EN, 40'h0000000000}, 8, 6'h00);
    frame(f, n, exp);
  endtask : mod
  function automatic logic [47:0] st(input logic tb, input logic [3:0] c);
    return {fswg_pkg::OP_WR_STATUS, 1'b0, c[3], tb, c[2:0], 2'h0, 32'h00000000};
  endfunction : st
  // Hang guard, about four times the expected run
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    end_sim();
  end
  // Test sequence
  initial begin
    i_host.idle(4);
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    frame({fswg_pkg::OP_WR_EN, 40'h0000000000}, 8, 6'h21);
    repeat (2000) @(posedge core_clk);
    rd(ST, 32'h000000BF, 32'h00000000, 2'h0);
    wr(fswg_pkg::REG_LOCK_SEL, 32'h00000005);
    rd(fswg_pkg::REG_LOCK_VIEW, 32'h00000003, 32'h00000001, 2'h0);
    rd(8'h20, 32'hFFFFFFFF, 32'h00000000, 2'h2);
    frame({SE, A5, 8'h00}, 40, 6'h23);
    frame({fswg_pkg::OP_WR_EN, 40'h0000000000}, 8, 6'h00);
    rd(ST, 32'h00000001, 32'h00000001, 2'h0);
    frame({SE, A5, 8'h00}, 40, 6'h27);
    mod({fswg_pkg::OP_WR_DIS, 40'h0000000000}, 8, 6'h00);
    rd(ST, 32'h00000001, 32'h00000000, 2'h0);
    $display("test power-on and latch done");
    mod({LCK, A5, 8'h00}, 48, 6'h00);
    mod({SE, A5, 8'h00}, 40, 6'h13);
    chk(34'(ea), 34'h0051234);
    mod({SE, A5, 8'h80}, 41, 6'h22);
    mod({PRG, 32'h02000000, 8'h00}, 40, 6'h25);
    mod({fswg_pkg::OP_SUB_ERASE, A5, 8'h00}, 40, 6'h12);
    for (int i = 0; i < 7; i++) begin
      mod(st(BPT[i][10], BPT[i][9:6]), 16, 6'h00);
      mod({PRG, A5, 8'h00}, 40, BPT[i][5:0]);
    end
    mod({fswg_pkg::OP_BULK_ERASE, 40'h0000000000}, 8, 6'h27);
    rd(fswg_pkg::REG_RESULT, 32'hFFFFFFFF, 32'h0008C707, 2'h0);
    $display("test protect codes done");
    wp_n <= 1'b0;
    mod(st(1'b0, 4'h5), 16, 6'h29);
    rd(ST, 32'h0000003E, 32'h00000020, 2'h0);
    wp_n <= 1'b1;
    mod({LCK, A5, 8'h02}, 48, 6'h00);
    mod({LCK, A5, 8'h01}, 48, 6'h28);
    rd(fswg_pkg::REG_LOCK_VIEW, 32'h00000003, 32'h00000002, 2'h0);
    mod({SE, A5, 8'h00}, 40, 6'h13);
    prog_old_byte <= 8'hF0;
    prog_new_byte <= 8'h3C;
    repeat (2) @(posedge core_clk);
    chk(34'(prog_merged_byte), 34'h030);
    $display("test pin and lock-down done");
    end_sim();
  end
endmodule : fswg_guard_tb
